// File: hdl/ldc_pkg.sv
// Purpose: Shared constants and types for the logical device config bank
// Assumes: One clock; byte address = {device, index, 2'b00}
// Notes: Table order fixes the cell numbering used by the top module
package ldc_pkg;

    // ****************************************
    // Table entry and carrier types
    // ****************************************
    typedef struct packed {
        logic [2:0] dev;   // Logical device number
        logic [7:0] idx;   // Configuration index
        logic [7:0] init;  // Value after reset
        logic [7:0] wmask; // Writable bits
        logic [7:0] fixed; // Read-only bit values
        logic keep;        // Survives soft reset
    } ldc_entry_t;

    // Requests coming from the keyboard controller core
    typedef struct packed {
        logic pointer_irq_req;
        logic keyboard_irq_req;
        logic aux_cmd;
    } ldc_keyb_in_t;

    // Registered side-band results
    typedef struct packed {
        logic pwr_runtime_access_en;
        logic pointer_interrupt_line;
        logic keyboard_interrupt_line;
        logic aux_cmd_forward;
    } ldc_side_t;

    // ****************************************
    // Address layout
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int DEV_LSB = 10;
    localparam int IDX_LSB = 2;
    localparam logic [2:0] DEV_IRSER = 3'h2;
    localparam logic [2:0] DEV_SER1 = 3'h3;
    localparam logic [2:0] DEV_PWR = 3'h4;
    localparam logic [2:0] DEV_PTR = 3'h5;
    localparam logic [2:0] DEV_KEYB = 3'h6;

    // Indexes inside one logical device
    localparam logic [7:0] IX_ACT = 8'h30;
    localparam logic [7:0] IX_RNG = 8'h31;
    localparam logic [7:0] IX_BH = 8'h60;
    localparam logic [7:0] IX_BL = 8'h61;
    localparam logic [7:0] IX_CBH = 8'h62;
    localparam logic [7:0] IX_CBL = 8'h63;
    localparam logic [7:0] IX_IRQS = 8'h70;
    localparam logic [7:0] IX_IRQT = 8'h71;
    localparam logic [7:0] IX_DMA0 = 8'h74;
    localparam logic [7:0] IX_DMA1 = 8'h75;
    localparam logic [7:0] IX_CFG = 8'hf0;

    // Write masks and fixed read values
    localparam logic [7:0] M_RW = 8'hff;
    localparam logic [7:0] M_RO = 8'h00;
    localparam logic [7:0] M_BH = 8'h07;
    localparam logic [7:0] M_BL3 = 8'hf8;
    localparam logic [7:0] M_BL1 = 8'hfe;
    localparam logic [7:0] M_IT1 = 8'h02;
    localparam logic [7:0] M_IT2 = 8'h03;
    localparam logic [7:0] F_CMD = 8'h04;
    localparam logic [7:0] F_IT = 8'h01;
    localparam logic [7:0] NO_DMA = 8'h04;

    // Reset values
    localparam logic [7:0] RV_ZERO = 8'h00;
    localparam logic [7:0] RV_IR_BH = 8'h02;
    localparam logic [7:0] RV_SER_BL = 8'hf8;
    localparam logic [7:0] RV_SER1_BH = 8'h03;
    localparam logic [7:0] RV_IR_IRQ = 8'h03;
    localparam logic [7:0] RV_SER_IT = 8'h03;
    localparam logic [7:0] RV_SER1_IRQ = 8'h04;
    localparam logic [7:0] RV_PTR_IRQ = 8'h0c;
    localparam logic [7:0] RV_KB_ACT = 8'h01;
    localparam logic [7:0] RV_KB_IRQ = 8'h01;
    localparam logic [7:0] RV_KB_IT = 8'h02;
    localparam logic [7:0] RV_KB_DBL = 8'h60;
    localparam logic [7:0] RV_KB_CBL = 8'h64;
    localparam logic [7:0] RV_IR_CFG = 8'h02;

    // ****************************************
    // Register table
    // ****************************************
    localparam int LDC_NUM = 40;
    localparam ldc_entry_t LDC_TABLE [LDC_NUM] = '{
        '{DEV_IRSER, IX_ACT, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_RNG, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_BH, RV_IR_BH, M_BH, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_BL, RV_SER_BL, M_BL3, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_IRQS, RV_IR_IRQ, M_RW, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_IRQT, RV_SER_IT, M_IT1, F_IT, 1'b0},
        '{DEV_IRSER, IX_DMA0, NO_DMA, M_RW, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_DMA1, NO_DMA, M_RW, RV_ZERO, 1'b0},
        '{DEV_IRSER, IX_CFG, RV_IR_CFG, M_RW, RV_ZERO, 1'b1},
        '{DEV_SER1, IX_ACT, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_SER1, IX_RNG, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_SER1, IX_BH, RV_SER1_BH, M_BH, RV_ZERO, 1'b0},
        '{DEV_SER1, IX_BL, RV_SER_BL, M_BL3, RV_ZERO, 1'b0},
        '{DEV_SER1, IX_IRQS, RV_SER1_IRQ, M_RW, RV_ZERO, 1'b0},
        '{DEV_SER1, IX_IRQT, RV_SER_IT, M_IT1, F_IT, 1'b0},
        '{DEV_SER1, IX_DMA0, NO_DMA, M_RO, NO_DMA, 1'b0},
        '{DEV_SER1, IX_DMA1, NO_DMA, M_RO, NO_DMA, 1'b0},
        '{DEV_SER1, IX_CFG, RV_ZERO, M_RW, RV_ZERO, 1'b1},
        '{DEV_PWR, IX_ACT, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_PWR, IX_RNG, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_PWR, IX_BH, RV_ZERO, M_BH, RV_ZERO, 1'b0},
        '{DEV_PWR, IX_BL, RV_ZERO, M_BL1, RV_ZERO, 1'b0},
        '{DEV_PWR, IX_DMA0, NO_DMA, M_RO, NO_DMA, 1'b0},
        '{DEV_PWR, IX_DMA1, NO_DMA, M_RO, NO_DMA, 1'b0},
        '{DEV_PTR, IX_ACT, RV_ZERO, M_RW, RV_ZERO, 1'b0},
        '{DEV_PTR, IX_IRQS, RV_PTR_IRQ, M_RW, RV_ZERO, 1'b0},
        '{DEV_PTR, IX_IRQT, RV_KB_IT, M_IT2, RV_ZERO, 1'b0},
        '{DEV_PTR, IX_DMA0, NO_DMA, M_RO, NO_DMA, 1'b0},
        '{DEV_PTR, IX_DMA1, NO_DMA, M_RO, NO_DMA, 1'b0},
        '{DEV_KEYB, IX_ACT, RV_KB_ACT, M_RW, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_RNG, RV_ZERO, M_RW, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_BH, RV_ZERO, M_BH, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_BL, RV_KB_DBL, M_BL3, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_CBH, RV_ZERO, M_BH, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_CBL, RV_KB_CBL, M_BL3, F_CMD, 1'b1},
        '{DEV_KEYB, IX_IRQS, RV_KB_IRQ, M_RW, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_IRQT, RV_KB_IT, M_IT2, RV_ZERO, 1'b1},
        '{DEV_KEYB, IX_DMA0, NO_DMA, M_RO, NO_DMA, 1'b1},
        '{DEV_KEYB, IX_DMA1, NO_DMA, M_RO, NO_DMA, 1'b1},
        '{DEV_KEYB, IX_CFG, RV_ZERO, M_RW, RV_ZERO, 1'b1}
    };

    // Cell numbers the top module looks at directly
    localparam int E_IR_BH = 2;
    localparam int E_IR_BL = 3;
    localparam int E_IR_IT = 5;
    localparam int E_IR_CFG = 8;
    localparam int E_SER1_DMA0 = 15;
    localparam int E_SER1_CFG = 17;
    localparam int E_PWR_ACT = 18;
    localparam int E_PTR_ACT = 24;
    localparam int E_KB_ACT = 29;
    localparam int E_KB_CBL = 34;
    localparam int E_KB_CFG = 39;

endpackage : ldc_pkg

// File: hdl/ldc_cfg_cell.sv
// Purpose: One 8-bit configuration byte with fixed and writable bits
// Assumes: Synchronous hard and soft reset on the same clock
// Notes: Read-only bits are forced on every bus write; resets load INIT unchanged
`timescale 1ns/100ps
`default_nettype none

module ldc_cfg_cell #(
    parameter logic [7:0] INIT = 8'h00,  // Value after reset
    parameter logic [7:0] WMASK = 8'hff, // Writable bits
    parameter logic [7:0] FIXED = 8'h00, // Read-only bit values
    parameter bit KEEP = 1'b0            // Ignore soft reset
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] value
);

    // ****************************************
    // Storage
    // ****************************************

    // Merged write: read-only lanes take their fixed value
    logic [7:0] next_value;
    assign next_value = (wdata & WMASK) | (FIXED & ~WMASK);

    // Hard reset first, then soft reset, then bus write
    always_ff @(posedge clk) begin
        if (rst) begin
            value <= INIT;
        end else if (soft_rst && !KEEP) begin
            // Soft reset beats a same-cycle write on reloadable bytes
            value <= INIT;
        end else if (we) begin
            value <= next_value;
        end
    end

endmodule : ldc_cfg_cell

`default_nettype wire

// File: hdl/ldc_config_bank.sv
// Purpose: APB register bank holding five logical device config sets
// Assumes: 20 MHz clk; soft_rst and keyboard controller requests come from clk logic
// Notes: Byte address is {device[2:0], index[7:0], 2'b00}
`timescale 1ns/100ps
`default_nettype none

module ldc_config_bank
    import ldc_pkg::*;
#(
    // Function config resets with no given value
    parameter logic [7:0] SER1_CFG_RESET = 8'h00,
    parameter logic [7:0] KEYB_CFG_RESET = 8'h00
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ldc_keyb_in_t keyb_in,
    output ldc_side_t side,
    output logic [7:0] cfg_value [LDC_NUM]
);

    // ****************************************
    // Address decode
    // ****************************************

    // True when the bus address names this table entry
    function automatic logic ldc_match(
        input ldc_entry_t ent,
        input logic [ADDR_W-1:0] addr
    );
        logic dev_ok;
        logic idx_ok;
        dev_ok = (addr[ADDR_W-1:DEV_LSB] == ent.dev);
        idx_ok = (addr[DEV_LSB-1:IDX_LSB] == ent.idx);
        // Only aligned words count
        return dev_ok && idx_ok && (addr[IDX_LSB-1:0] == 2'b00);
    endfunction : ldc_match

    // Setup cycle of an APB transfer
    logic setup;
    assign setup = psel && !penable;

    // Access edge: the one edge where a write lands
    logic access;
    assign access = psel && penable && pready;

    // One-hot entry hit for the current address
    logic [LDC_NUM-1:0] hit;
    logic any_hit;
    assign any_hit = |hit;

    // Hit vector, one compare per entry
    always_comb begin
        for (int i = 0; i < LDC_NUM; i++) begin
            hit[i] = ldc_match(LDC_TABLE[i], paddr);
        end
    end

    // Read mux; a miss reads as zero
    logic [7:0] next_rbyte;
    always_comb begin
        next_rbyte = 8'h00;
        for (int i = 0; i < LDC_NUM; i++) begin
            if (hit[i]) begin
                next_rbyte = next_rbyte | cfg_value[i];
            end
        end
    end

    // ****************************************
    // Configuration cells
    // ****************************************

    // One cell per table entry; masks and fixed bits come from the table
    generate
        for (genvar g = 0; g < LDC_NUM; g++) begin : g_cell
            // Two function config bytes take a module parameter
            localparam logic [7:0] CELL_INIT =
                (g == E_SER1_CFG) ? SER1_CFG_RESET :
                (g == E_KB_CFG) ? KEYB_CFG_RESET :
                LDC_TABLE[g].init;
            // Write strobe only for a hit on the access edge
            logic cell_we;
            assign cell_we = access && pwrite && hit[g];
            ldc_cfg_cell #(
                .INIT(CELL_INIT),
                .WMASK(LDC_TABLE[g].wmask),
                .FIXED(LDC_TABLE[g].fixed),
                .KEEP(LDC_TABLE[g].keep)
            ) u_cell (
                .clk(clk),
                .rst(rst),
                .soft_rst(soft_rst),
                .we(cell_we),
                .wdata(pwdata[7:0]),
                .value(cfg_value[g])
            );
        end
    endgenerate

    // ****************************************
    // APB response
    // ****************************************

    // Ready one cycle after setup; every transfer takes two cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Unmapped address flags an error; its write is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !any_hit;
        end
    end

    // Read data captured at setup, held through the access phase
    // Capturing at setup keeps the wide read mux off the output path
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            // Upper 24 bits always read zero
            prdata <= {24'h00_0000, next_rbyte};
        end
    end

    // ****************************************
    // Side-band controls
    // ****************************************

    // Side-band flops, one per concern, gathered onto the side port below
    logic pwr_access_en; // Power runtime window open
    logic pointer_line; // Gated pointer interrupt
    logic keyboard_line; // Gated keyboard interrupt
    logic aux_forward; // Copy of the aux command request

    // Power runtime window follows activate bit 0; data kept elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_access_en <= 1'b0;
        end else begin
            pwr_access_en <= cfg_value[E_PWR_ACT][0];
        end
    end

    // Pointer line forced low while that device is inactive
    always_ff @(posedge clk) begin
        if (rst) begin
            pointer_line <= 1'b0;
        end else begin
            pointer_line <=
                cfg_value[E_PTR_ACT][0] && keyb_in.pointer_irq_req;
        end
    end

    // Keyboard line gated by its own activate bit
    always_ff @(posedge clk) begin
        if (rst) begin
            keyboard_line <= 1'b0;
        end else begin
            keyboard_line <=
                cfg_value[E_KB_ACT][0] && keyb_in.keyboard_irq_req;
        end
    end

    // Aux commands pass whatever the pointer activate holds
    always_ff @(posedge clk) begin
        if (rst) begin
            aux_forward <= 1'b0;
        end else begin
            aux_forward <= keyb_in.aux_cmd;
        end
    end

    // One driver for the whole struct; field order of ldc_side_t, MSB first
    assign side = {pwr_access_en, pointer_line, keyboard_line, aux_forward};

    // ****************************************
    // Checks
    // ****************************************

    // Every check samples on the rising edge and sleeps during hard reset
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    // Helper: a bus write is landing this edge
    logic wr_now;
    assign wr_now = access && pwrite;

    // Ready follows setup by exactly one edge, then drops
    a_apb_ready_timing:
    assert property (setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");

    // Unmapped access always answers with an error
    a_apb_unmapped_err:
    assert property (setup && !any_hit |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");

    // IR serial high base byte never shows decoded bits above A10
    a_base_high_zero:
    assert property (cfg_value[E_IR_BH][7:3] == 5'h00)
        else $error("base high upper bits not zero");

    // Soft reset reloads the IR serial low base byte
    a_irser_soft_reload:
    assert property (soft_rst |=> cfg_value[E_IR_BL] == RV_SER_BL)
        else $error("IR serial base low not reloaded");

    // Serial interrupt type keeps bit 0 set and 7..2 clear
    a_serial_irqt_fixed:
    assert property (cfg_value[E_IR_IT][0] && cfg_value[E_IR_IT][7:2] == 6'h00)
        else $error("serial interrupt type fixed bits lost");

    // Read-only DMA report never moves, even across writes
    a_no_dma_report:
    assert property (hit[E_SER1_DMA0] && wr_now |=> cfg_value[E_SER1_DMA0] == NO_DMA)
        else $error("DMA report changed");

    // Keyboard activate survives a soft reset with no write
    a_keyb_soft_keep:
    assert property (soft_rst && !wr_now |=> $stable(cfg_value[E_KB_ACT]))
        else $error("keyboard activate lost on soft reset");

    // IR function config holds through soft reset
    a_func_cfg_keep:
    assert property (soft_rst && !wr_now |=> $stable(cfg_value[E_IR_CFG]))
        else $error("function config changed on soft reset");

    // Command base low comes out of hard reset at its default
    a_keyb_cmd_reset:
    assert property ($fell(rst) |-> cfg_value[E_KB_CBL] == RV_KB_CBL)
        else $error("command base low wrong after reset");

    // Command base low bits always read 100
    a_keyb_cmd_fixed:
    assert property (cfg_value[E_KB_CBL][2:0] == F_CMD[2:0])
        else $error("command base low fixed bits lost");

    // Inactive pointer: line low one edge later
    a_pointer_gated:
    assert property (!cfg_value[E_PTR_ACT][0] |=> !side.pointer_interrupt_line)
        else $error("pointer line high while inactive");

    // Power window closes one edge after activate clears
    a_pwr_window:
    assert property ($fell(cfg_value[E_PWR_ACT][0]) |-> ##1 !side.pwr_runtime_access_en)
        else $error("power runtime window still open");

    // Aux forward copies its request regardless of activation
    a_aux_forward:
    assert property (!$past(rst) |-> side.aux_cmd_forward == $past(keyb_in.aux_cmd))
        else $error("aux command path disturbed");

    // Error answers only ride on a ready pulse
    a_err_with_ready:
    assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    // Upper read lanes are never driven
    a_prdata_upper:
    assert property (prdata[31:8] == 24'h00_0000)
        else $error("prdata upper bits set");

    // IR serial low base keeps its three fixed zeros
    a_irser_low_zero:
    assert property (cfg_value[E_IR_BL][2:0] == 3'h0)
        else $error("IR base low fixed bits lost");

    // IR serial base comes out of hard reset at its defaults
    a_irser_base_reset:
    assert property ($fell(rst) |-> cfg_value[E_IR_BH] == RV_IR_BH && cfg_value[E_IR_BL] == RV_SER_BL)
        else $error("IR base wrong after reset");

    // IR function config comes out of hard reset at its default
    a_irser_cfg_reset:
    assert property ($fell(rst) |-> cfg_value[E_IR_CFG] == RV_IR_CFG)
        else $error("IR function config wrong after reset");

    // Keyboard activate comes out of hard reset set
    a_keyb_act_reset:
    assert property ($fell(rst) |-> cfg_value[E_KB_ACT] == RV_KB_ACT)
        else $error("keyboard activate wrong after reset");

    // Second serial DMA report reads no channel at all times
    a_ser1_dma_fixed:
    assert property (cfg_value[E_SER1_DMA0] == NO_DMA)
        else $error("DMA report not fixed");

    // Second serial function config holds through soft reset
    a_ser1_cfg_keep:
    assert property (soft_rst && !wr_now |=> $stable(cfg_value[E_SER1_CFG]))
        else $error("serial function config lost");

    // Keyboard function config holds through soft reset
    a_keyb_cfg_keep:
    assert property (soft_rst && !wr_now |=> $stable(cfg_value[E_KB_CFG]))
        else $error("keyboard function config lost");

    // Active pointer passes its request one edge later
    a_pointer_follows:
    assert property (cfg_value[E_PTR_ACT][0] && keyb_in.pointer_irq_req |=> side.pointer_interrupt_line)
        else $error("pointer line missing while active");

    // Power window opens one edge after activate sets
    a_pwr_window_open:
    assert property ($rose(cfg_value[E_PWR_ACT][0]) |=> side.pwr_runtime_access_en)
        else $error("power runtime window not opened");

endmodule : ldc_config_bank

`default_nettype wire

// File: tb/ldc_host_model.sv
// Purpose: APB master model standing in for host configuration software
// Assumes: One byte register per aligned word, slave answers with pready
// Notes: Waits for pready without limit; the bench watchdog cuts a hang
`timescale 1ns/100ps
`default_nettype none

module ldc_host_model
    import ldc_pkg::*;
(
    input wire logic clk,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [ADDR_W-1:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ****************************************
    // Bus master
    // ****************************************
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h00000000;
    end

    // One transfer; request held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // Sampled values only, so no race with the slave's flops
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : ldc_host_model
`default_nettype wire

// File: tb/logical_device_config_regs_tb.sv
// Purpose: Self-checking bench for the logical device config bank
// Assumes: 20 MHz clock, synchronous active-high resets
// Notes: Expected bytes come from the bench's own table, not the package's
`timescale 1ns/100ps
`default_nettype none

module logical_device_config_regs_tb
    import ldc_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic clk, rst, soft_rst;
    logic psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    ldc_keyb_in_t keyb_in; // Keyboard core requests
    ldc_side_t side; // Registered side-band results
    logic [7:0] cfg_value [LDC_NUM];
    int errors, cmp_count;

    // {device (bit 7 = survives soft reset), index, reset, after ff, after 00}
    localparam logic [39:0] EXP [40] = '{
        40'h023000ff00, 40'h023100ff00, 40'h0260020700, 40'h0261f8f800, 40'h027003ff00,
        40'h0271030301, 40'h027404ff00, 40'h027504ff00, 40'h82f002ff00, 40'h033000ff00,
        40'h033100ff00, 40'h0360030700, 40'h0361f8f800, 40'h037004ff00, 40'h0371030301,
        40'h0374040404, 40'h0375040404, 40'h83f000ff00, 40'h043000ff00, 40'h043100ff00,
        40'h0460000700, 40'h046100fe00, 40'h0474040404, 40'h0475040404, 40'h053000ff00,
        40'h05700cff00, 40'h0571020300, 40'h0574040404, 40'h0575040404, 40'h863001ff00,
        40'h863100ff00, 40'h8660000700, 40'h866160f800, 40'h8662000700, 40'h866364fc04,
        40'h867001ff00, 40'h8671020300, 40'h8674040404, 40'h8675040404, 40'h86f000ff00};

    // ****************************************
    // Clock, design and host
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ldc_config_bank dut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .keyb_in(keyb_in), .side(side), .cfg_value(cfg_value));

    ldc_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [ADDR_W-1:0] rg(input logic [2:0] d, input logic [7:0] x);
        return {d, x, 2'b00};
    endfunction : rg

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Hard reset held for 16 cycles
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // Walk all bytes: 0 reset, 1 write ff, 2 after soft reset, 3 write 00
    task automatic sweep(input int mode);
        logic [39:0] e;
        logic [31:0] rd;
        logic err;
        logic [7:0] want;
        for (int i = 0; i < 40; i++) begin
            e = EXP[i];
            if (mode == 1) host.xfer(1'b1, rg(e[34:32], e[31:24]), 8'hff, rd, err);
            if (mode == 3) host.xfer(1'b1, rg(e[34:32], e[31:24]), 8'h00, rd, err);
            host.xfer(1'b0, rg(e[34:32], e[31:24]), 8'h00, rd, err);
            case (mode)
                0: want = e[23:16];
                1: want = e[15:8];
                2: want = e[39] ? e[15:8] : e[23:16];
                default: want = e[7:0];
            endcase
            check(rd, {24'h000000, want}, $sformatf("byte %h", e[39:24]));
            check({31'h0, err}, 32'h0, "mapped error flag");
            check({24'h000000, cfg_value[i]}, {24'h000000, want}, "config byte");
        end
    endtask : sweep

    task automatic side_after(input logic [3:0] want);
        repeat (2) @(negedge clk);
        check({28'h0, side}, {28'h0, want}, "side outputs");
    endtask : side_after

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_values;
        sweep(0);
        $display("test_reset_values done");
    endtask : test_reset_values

    task automatic test_write_masks;
        sweep(1);
        sweep(3);
        $display("test_write_masks done");
    endtask : test_write_masks

    // All activates are zero on entry
    task automatic test_side;
        logic [31:0] rd;
        logic err;
        @(posedge clk);
        keyb_in <= 3'b111;
        side_after(4'h1);
        host.xfer(1'b1, rg(DEV_PWR, IX_ACT), 8'h01, rd, err);
        host.xfer(1'b1, rg(DEV_PTR, IX_ACT), 8'h01, rd, err);
        host.xfer(1'b1, rg(DEV_KEYB, IX_ACT), 8'h01, rd, err);
        side_after(4'hf);
        @(posedge clk);
        keyb_in <= 3'b000;
        side_after(4'h8);
        host.xfer(1'b1, rg(DEV_PTR, IX_ACT), 8'h00, rd, err);
        @(posedge clk);
        keyb_in <= 3'b101;
        side_after(4'h9);
        $display("test_side done");
    endtask : test_side

    task automatic test_unmapped;
        logic [31:0] rd;
        logic err;
        host.xfer(1'b1, rg(3'h0, IX_ACT), 8'h55, rd, err);
        check({31'h0, err}, 32'h1, "unmapped write error");
        host.xfer(1'b0, rg(3'h0, IX_ACT), 8'h00, rd, err);
        check(rd, 32'h0, "unmapped read data");
        check({31'h0, err}, 32'h1, "unmapped read error");
        host.xfer(1'b1, rg(DEV_KEYB, IX_ACT) | 13'h0002, 8'h00, rd, err);
        check({31'h0, err}, 32'h1, "misaligned error");
        host.xfer(1'b0, rg(DEV_KEYB, IX_ACT), 8'h00, rd, err);
        check(rd, 32'h1, "misaligned write dropped");
        $display("test_unmapped done");
    endtask : test_unmapped

    task automatic test_soft_reset;
        sweep(1);
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        sweep(2);
        $display("test_soft_reset done");
    endtask : test_soft_reset

    task automatic test_hard_reset;
        do_reset();
        sweep(0);
        $display("test_hard_reset done");
    endtask : test_hard_reset

    // ****************************************
    // Sequence, watchdog and verdict
    // ****************************************
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst = 1'b1;
        soft_rst = 1'b0;
        keyb_in = '0;
        errors = 0;
        cmp_count = 0;
        do_reset();
        test_reset_values();
        test_write_masks();
        test_side();
        test_unmapped();
        test_soft_reset();
        test_hard_reset();
        wrap_up();
    end

    // About seventeen times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : logical_device_config_regs_tb
`default_nettype wire
